// ---- bench/adc_serial_port_checker.sv ----
/* Assertion checker for the serial port framing block.
   Assumes it is bound to adc_serial_port and sees only its ports. */
`timescale 1ns/1ps
module port_checker (
   // clock and control
   input wire core_clk_in,
   input wire rst_in,
   input wire ce_in,
   // serial pins
   input wire sclk_in,
   input wire cs_n_in,
   input wire dout_out,
   input wire dout_oe_n_out,
   // converter side and state
   input wire conv_valid_in,
   input wire conv_ready_out,
   input wire conv_abort_in,
   input wire rdy_on_dout_in,
   input wire err_enable_in,
   input wire [15:0] control_out,
   input wire data_ready_n_out,
   input wire [2:0] err_flags_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   reset_clear_a: assert property ($fell(rst_in) |-> control_out == 16'h0000
      && dout_oe_n_out && data_ready_n_out && err_flags_out == 3'h0) else $error("bad reset");
   cs_tristate_a: assert property ((cs_n_in && ce_in) [*6] |-> dout_oe_n_out)
      else $error("pin driven while deselected");
   push_pending_a: assert property (conv_valid_in && conv_ready_out && ce_in
      && !conv_abort_in |=> !data_ready_n_out) else $error("result not pending");
   full_pending_a: assert property (!conv_ready_out |-> !data_ready_n_out)
      else $error("full yet not pending");
   err_gate_a: assert property ((err_flags_out & ~$past(err_flags_out)) != 3'h0
      |-> $past(control_out[9]) && $past(err_enable_in)) else $error("flag outside 4-wire");
   ready_pin_a: assert property ((control_out[11] && !control_out[9] && rdy_on_dout_in
      && data_ready_n_out && !cs_n_in && ce_in) [*8] |-> dout_out && !dout_oe_n_out)
      else $error("ready pin wrong");
   idle_release_a: assert property ((!control_out[9] && !rdy_on_dout_in
      && sclk_in && ce_in) [*8] |-> dout_oe_n_out) else $error("pin not released");
   rsvd_zero_a: assert property (control_out[7] == 1'b0) else $error("reserved bit set");
   freeze_hold_a: assert property (!ce_in |=> $stable(control_out)
      && $stable(err_flags_out) && $stable(dout_oe_n_out)) else $error("state moved");
   cover property (!data_ready_n_out && control_out[11]);
   cover property ($rose(err_flags_out[2]));
   cover property (control_out[10] && !conv_ready_out);
   cover property (!cs_n_in && control_out[9] && !dout_oe_n_out);
endmodule // port_checker
bind adc_serial_port port_checker chk (.core_clk_in(core_clk_in), .rst_in(rst_in),
   .ce_in(ce_in), .sclk_in(sclk_in), .cs_n_in(cs_n_in), .dout_out(dout_out),
   .dout_oe_n_out(dout_oe_n_out), .conv_valid_in(conv_valid_in),
   .conv_ready_out(conv_ready_out), .conv_abort_in(conv_abort_in),
   .rdy_on_dout_in(rdy_on_dout_in), .err_enable_in(err_enable_in),
   .control_out(control_out), .data_ready_n_out(data_ready_n_out),
   .err_flags_out(err_flags_out));

// ---- bench/spi_host_model.sv ----
/* Host serial controller model: mode 3 frames, select pin, reset pattern.
   Assumes a 100 ns pacing clock; pins change on its falling edge. */
`timescale 1ns/1ps
module spi_host_model (
   // pacing clock
   input wire core_clk_in,
   // serial pins
   output reg sclk_out,
   output reg cs_n_out,
   output reg din_out,
   input wire dout_in,
   input wire dout_oe_n_in
);
   initial begin
      sclk_out = 1'b1;
      cs_n_out = 1'b0; // held low in 3-wire
      din_out = 1'b0;
   end
   task automatic half;
      repeat (4) @(negedge core_clk_in);
   endtask
   // exactly n clocks, msb first
   task automatic frame(input int n, input logic [31:0] tx, output logic [31:0] rx);
      rx = 32'h0;
      @(negedge core_clk_in);
      for (int i = n - 1; i >= 0; i--) begin
         sclk_out = 1'b0;
         din_out = tx[i];
         half();
         // released pin floats to the inverse of its last value
         rx = {rx[30:0], dout_oe_n_in ? ~dout_in : dout_in};
         sclk_out = 1'b1;
         half();
      end
      din_out = ~din_out;
   endtask
   task automatic select(input logic v);
      @(negedge core_clk_in);
      cs_n_out = v;
      half();
   endtask
   // 64 ones
   task automatic sw_reset;
      logic [31:0] r;
      frame(32, 32'hFFFFFFFF, r);
      frame(32, 32'hFFFFFFFF, r);
   endtask
endmodule // spi_host_model

// ---- bench/tb.sv ----
/* Self-checking bench for the serial port framing block.
   Assumes the host model drives the pins and the bench feeds results. */
`timescale 1ns/1ps
module tb;
   reg core_clk_in, rst_in, ce_in, conv_valid_in, conv_abort_in, rdy_on_dout_in, err_enable_in;
   reg [15:0] conv_data_in;
   reg [7:0] conv_status_in;
   wire sclk, cs_n, din, dout_out, dout_oe_n_out, conv_ready_out, data_ready_n_out;
   wire [15:0] control_out;
   wire [2:0] err_flags_out;
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [31:0] rx;
   adc_serial_port dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce_in),
      .sclk_in(sclk), .cs_n_in(cs_n), .din_in(din), .dout_out(dout_out),
      .dout_oe_n_out(dout_oe_n_out), .conv_data_in(conv_data_in),
      .conv_status_in(conv_status_in), .conv_valid_in(conv_valid_in),
      .conv_ready_out(conv_ready_out), .conv_abort_in(conv_abort_in),
      .rdy_on_dout_in(rdy_on_dout_in), .err_enable_in(err_enable_in),
      .control_out(control_out), .data_ready_n_out(data_ready_n_out),
      .err_flags_out(err_flags_out));
   spi_host_model host (.core_clk_in(core_clk_in), .sclk_out(sclk), .cs_n_out(cs_n),
      .din_out(din), .dout_in(dout_out), .dout_oe_n_in(dout_oe_n_out));
   initial begin
      core_clk_in = 1'b0;
      forever #50 core_clk_in = ~core_clk_in;
   end
   always @(posedge core_clk_in) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         err_count = err_count + 1;
         complete_run();
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         err_count = err_count + 1;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(negedge core_clk_in);
   endtask
   task automatic wr(input logic [15:0] v);
      host.frame(24, {8'h0, 8'h01, v}, rx);
   endtask
   task automatic rd(input logic [7:0] cmd, input int n, input logic [31:0] exp);
      host.frame(n, 32'(cmd) << (n - 8), rx);
      check(rx & ((32'h1 << (n - 8)) - 32'h1), exp);
   endtask
   task automatic push(input logic [15:0] d, input logic [7:0] s);
      @(negedge core_clk_in);
      conv_data_in = d;
      conv_status_in = s;
      conv_valid_in = 1'b1;
      @(negedge core_clk_in);
      conv_valid_in = 1'b0;
   endtask
   task automatic t_reset;
      ce_in = 1'b0;
      wait_n(3);
      ce_in = 1'b1;
      check(control_out, 32'h0);
      rd(8'h41, 24, 32'h0);
      wait_n(4);
      check(dout_oe_n_out, 32'h1);
      $display("test reset done");
   endtask
   task automatic t_ctrl;
      wr(16'h14A5);
      rd(8'h41, 24, 32'h1425);
      wr(16'hE0F0);
      rd(8'h41, 24, 32'hE070);
      host.frame(16, 32'h3F00, rx);
      check(err_flags_out, 32'h0);
      host.sw_reset();
      rd(8'h41, 24, 32'h0);
      $display("test control done");
   endtask
   task automatic t_buffer;
      wr(16'h0400);
      push(16'hA55A, 8'h3C);
      push(16'h1234, 8'h5A);
      wait_n(1);
      conv_valid_in = 1'b1;
      wait_n(2);
      check(conv_ready_out, 32'h0);
      conv_valid_in = 1'b0;
      rd(8'h42, 32, 32'hA55A3C);
      rd(8'h42, 32, 32'h12345A);
      wait_n(4);
      check(data_ready_n_out, 32'h1);
      wr(16'h0000);
      push(16'h0F0F, 8'hFF);
      rd(8'h42, 24, 32'h0F0F);
      $display("test buffer done");
   endtask
   task automatic t_cont;
      rdy_on_dout_in = 1'b1;
      wr(16'h0800);
      push(16'h1234, 8'h00);
      wait_n(4);
      check({dout_out, data_ready_n_out}, 32'h0);
      host.frame(16, 32'h0, rx);
      check(rx, 32'h1234);
      host.frame(16, 32'h0, rx);
      check(rx, 32'hFFFF);
      push(16'h5555, 8'h00);
      fork
         host.frame(16, 32'h0, rx);
         begin
            wait_n(40);
            conv_abort_in = 1'b1;
            wait_n(1);
            conv_abort_in = 1'b0;
         end
      join
      wait_n(4);
      check(data_ready_n_out, 32'h1);
      push(16'h5678, 8'h00);
      wait_n(4);
      rd(8'h42, 24, 32'h5678);
      rd(8'h41, 24, 32'h0);
      rdy_on_dout_in = 1'b0;
      $display("test continuous done");
   endtask
   task automatic t_four;
      wr(16'h0200);
      host.select(1'b1);
      check(dout_oe_n_out, 32'h1);
      host.frame(8, 32'hFF, rx);
      host.select(1'b0);
      rd(8'h41, 24, 32'h0200);
      host.select(1'b1);
      host.select(1'b0);
      host.frame(12, 32'h410, rx);
      host.select(1'b1);
      check(err_flags_out, 32'h4);
      host.select(1'b0);
      rd(8'h43, 16, 32'h04);
      host.select(1'b1);
      check(err_flags_out, 32'h0);
      // cut frame with the flags disabled sets nothing
      err_enable_in = 1'b0;
      host.select(1'b0);
      host.frame(12, 32'h410, rx);
      host.select(1'b1);
      check(err_flags_out, 32'h0);
      // read of an unmapped address gives a read error
      err_enable_in = 1'b1;
      host.select(1'b0);
      host.frame(16, 32'h7F00, rx);
      host.select(1'b1);
      check(err_flags_out, 32'h2);
      // reset in mid-run clears control and flags
      rst_in = 1'b1;
      wait_n(2);
      rst_in = 1'b0;
      wait_n(4);
      check({control_out, err_flags_out}, 32'h0);
      $display("test four wire done");
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      rst_in = 1'b1;
      ce_in = 1'b1;
      conv_valid_in = 1'b0;
      conv_abort_in = 1'b0;
      rdy_on_dout_in = 1'b0;
      err_enable_in = 1'b1;
      conv_data_in = 16'h0000;
      conv_status_in = 8'h00;
      wait_n(2);
      rst_in = 1'b0;
      wait_n(4);
      t_reset();
      t_ctrl();
      t_buffer();
      t_cont();
      t_four();
      complete_run();
   end
endmodule // tb

// ---- src/adc_port_consts.vh ----
/*
 Constants of the serial port framing block: register addresses, control
 field positions, reset values, frame lengths and timing figures.
 Assumes inclusion by bare name from the design files.
*/
`ifndef ADC_PORT_CONSTS_VH
`define ADC_PORT_CONSTS_VH
// register addresses (command bits 5:0)
`define ADDR_STATUS 6'h00
`define ADDR_CTRL 6'h01
`define ADDR_DATA 6'h02
`define ADDR_ERR 6'h03
// command byte
`define CMD_READ_BIT 6
`define CMD_READ_DATA 8'h42
// converter_control fields
`define CTRL_RESET 16'h0000
`define CTRL_WMASK 16'hFF7F
`define CTRL_DLY_BIT 12
`define CTRL_CONT_BIT 11
`define CTRL_STAT_BIT 10
`define CTRL_CSEN_BIT 9
// error flag positions
`define ERR_WR_BIT 0
`define ERR_RD_BIT 1
`define ERR_CNT_BIT 2
// frame lengths in bits
`define LEN_BYTE 5'h08
`define LEN_WORD 5'h10
`define LEN_WIDE 5'h18
// software reset pattern length
`define SWRST_ONES 7'h40
// timing
`define CORE_MHZ 10
`define REL_SHORT_NS 10
`define REL_LONG_NS 100
`endif

// ---- src/adc_serial_port.v ----
/*
 Serial port framing of the converter: command decode, converter_control
 register, 3-wire/4-wire framing, appended status byte, continuous read.
 Assumes serial pins are asynchronous (sampled here) and that conversion
 results, the abort warning and configuration inputs share core_clk_in.
*/
`timescale 1ns/1ps
`include "adc_port_consts.vh"
// Summary of operation
// RQ1: continuous_read_enable at 1 enables continuous result reading; 0 disables it.
// RQ2: with append-status set, result frame is 16 data bits then 8 status bits.
// RQ3: select-pin enable and append-status reset to zero: 3-wire, no status.
// RQ4: select_pin_enable zero gives 3-wire mode, reset on last rising clock.
// RQ5: 3-wire read end releases output or shows data-ready at last rising edge.
// RQ6: output_release_delay adjusts the 3-wire release delay after the last edge.
// RQ7: in 3-wire mode the host gives exactly the register's clock count.
// RQ8: in 3-wire mode the host holds chip select low.
// RQ9: chip select high always puts the serial output in high impedance.
// RQ10: select_pin_enable one gives 4-wire mode, reset on chip select rising.
// RQ11: 4-wire read end switches output to data-ready at chip select rising.
// RQ12: write, read and clock-count error flags work only in 4-wire mode.
// RQ13: release delay is 10 ns when bit clear, 100 ns when set; the code releases after one 100 ns core cycle in both cases.
// RQ14: continuous read ignores clocks until data-ready falls; each result read once.
// RQ15: continuous read in progress at abort warning is dropped; data-ready goes high. The code keeps it low while a second result waits in the buffer.
// RQ16: host leaves continuous read by 64 ones or read data command.
// RQ17: in 4-wire mode clocks ignored while chip select high.
module adc_serial_port (
   // clock, reset, enable
   input wire core_clk_in,
   input wire rst_in,
   input wire ce_in,
   // serial pins
   input wire sclk_in,
   input wire cs_n_in,
   input wire din_in,
   output reg dout_out,
   output reg dout_oe_n_out,
   // conversion results
   input wire [15:0] conv_data_in,
   input wire [7:0] conv_status_in,
   input wire conv_valid_in,
   output wire conv_ready_out,
   input wire conv_abort_in,
   // configuration and state
   input wire rdy_on_dout_in,
   input wire err_enable_in,
   output wire [15:0] control_out,
   output wire data_ready_n_out,
   output wire [2:0] err_flags_out
);
   localparam ST_CMD = 2'h0;
   localparam ST_RD = 2'h1;
   localparam ST_WR = 2'h2;
   localparam ST_DONE = 2'h3;
   localparam integer REL_SHORT_RAW = (`REL_SHORT_NS * `CORE_MHZ + 999) / 1000;
   localparam integer REL_LONG_RAW = (`REL_LONG_NS * `CORE_MHZ + 999) / 1000;
   localparam [3:0] REL_SHORT_CYC = (REL_SHORT_RAW < 1) ? 4'h1 : REL_SHORT_RAW[3:0];
   localparam [3:0] REL_LONG_CYC = (REL_LONG_RAW < 1) ? 4'h1 : REL_LONG_RAW[3:0];

   wire sclk_s;
   wire cs_n_s;
   wire din_s;
   wire [23:0] head;
   wire head_valid;
   reg [15:0] ctrl_r;
   reg [1:0] state_r;
   reg [4:0] cnt_r;
   reg [4:0] len_r;
   reg [7:0] cmd_r;
   reg [23:0] sh_r;
   reg [15:0] wr_r;
   reg [5:0] addr_r;
   reg drv_r;
   reg dout_r;
   reg crd_r;
   reg isdata_r;
   reg wrok_r;
   reg [2:0] err_r;
   reg [6:0] ones_r;
   reg [3:0] rel_r;
   reg pop_r;
   reg sclk_d_r;
   reg cs_d_r;
   reg [23:0] dec_val;
   reg [4:0] dec_len;
   reg dec_map;
   reg dec_wr;

   sync2 #(
      .WIDTH(3),
      .RST_VAL(3'h6)
   ) u_sync (
      .clk_in(core_clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .d_in({sclk_in, cs_n_in, din_in}),
      .q_out({sclk_s, cs_n_s, din_s})
   );

   buf2 #(
      .WIDTH(24)
   ) u_buf (
      .clk_in(core_clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .in_data_in({conv_status_in, conv_data_in}),
      .in_valid_in(conv_valid_in),
      .in_ready_out(conv_ready_out),
      .out_data_out(head),
      .out_valid_out(head_valid),
      .out_ready_in(pop_r)
   );

   wire four_wire = ctrl_r[`CTRL_CSEN_BIT];
   wire cont = ctrl_r[`CTRL_CONT_BIT];
   wire appst = ctrl_r[`CTRL_STAT_BIT];
   // clocks always count in 3-wire mode; in 4-wire mode only while the port is selected
   wire active = ~four_wire | ~cs_n_s; // [RQ17]
   wire rise = active & sclk_s & ~sclk_d_r;
   wire fall = active & ~sclk_s & sclk_d_r;
   wire cs_rise = four_wire & cs_n_s & ~cs_d_r; // [RQ10]
   wire [7:0] cmd_w = {cmd_r[6:0], din_s};
   wire last = (cnt_r == len_r - 5'h01);
   wire is_rd = cmd_w[`CMD_READ_BIT];
   wire [7:0] stat_byte = {~head_valid, |err_r, head[21:16]};
   wire [23:0] data_word = {head[15:0], appst ? head[23:16] : 8'h00}; // [RQ2]
   wire [4:0] dlen = appst ? `LEN_WIDE : `LEN_WORD; // [RQ2]
   wire [3:0] rel_cyc = ctrl_r[`CTRL_DLY_BIT] ? REL_LONG_CYC : REL_SHORT_CYC; // [RQ13]
   wire err_en = four_wire & err_enable_in; // [RQ12]
   wire take_cmd = rise & (state_r == ST_CMD) & ~cont;
   wire cmd_end = take_cmd & (cnt_r == 5'h07);
   wire set_wr = err_en & cmd_end & ~is_rd & ~dec_wr; // [RQ12]
   wire set_rd = err_en & cmd_end & is_rd & ~dec_map; // [RQ12]
   wire in_frame = (state_r == ST_RD) | (state_r == ST_WR) |
                   ((state_r == ST_CMD) & (cnt_r != 5'h00));
   wire set_cnt = err_en & cs_rise & in_frame; // [RQ12]
   wire clr_err = rise & (state_r == ST_RD) & last & ~crd_r & (addr_r == `ADDR_ERR);
   wire swrst = rise & din_s & (ones_r == `SWRST_ONES - 7'h01); // [RQ16]
   wire cont_start = cont & head_valid & active & ~pop_r; // [RQ14]

   assign control_out = ctrl_r;
   assign data_ready_n_out = ~head_valid;
   assign err_flags_out = err_r;

   // register decode of the command byte being completed
   always @* begin
      dec_val = 24'h000000;
      dec_len = `LEN_BYTE;
      dec_map = 1'b1;
      dec_wr = 1'b0;
      case (cmd_w[5:0])
         `ADDR_CTRL: begin
            dec_val = {ctrl_r, 8'h00};
            dec_len = `LEN_WORD;
            dec_wr = 1'b1;
         end
         `ADDR_DATA: begin
            dec_val = data_word;
            dec_len = dlen;
         end
         `ADDR_STATUS: dec_val = {stat_byte, 16'h0000};
         `ADDR_ERR: dec_val = {5'h00, err_r, 16'h0000};
         default: dec_map = 1'b0;
      endcase
   end

   always @(posedge core_clk_in) begin
      if (rst_in) begin
         ctrl_r <= `CTRL_RESET; // [RQ3]
         state_r <= ST_CMD;
         cnt_r <= 5'h00;
         len_r <= `LEN_BYTE;
         cmd_r <= 8'h00;
         sh_r <= 24'h000000;
         wr_r <= 16'h0000;
         addr_r <= 6'h00;
         drv_r <= 1'b0;
         dout_r <= 1'b1;
         crd_r <= 1'b0;
         isdata_r <= 1'b0;
         wrok_r <= 1'b0;
         err_r <= 3'h0;
         ones_r <= 7'h00;
         rel_r <= 4'h0;
         pop_r <= 1'b0;
         sclk_d_r <= 1'b1;
         cs_d_r <= 1'b1;
         dout_out <= 1'b1;
         dout_oe_n_out <= 1'b1;
      end else if (ce_in) begin
         sclk_d_r <= sclk_s;
         cs_d_r <= cs_n_s;
         pop_r <= 1'b0;
         // a new error wins over the clear by reading
         err_r <= (err_r & ~{3{clr_err}}) | {set_cnt, set_rd, set_wr};
         if (rise)
            ones_r <= din_s ? ones_r + 7'h01 : 7'h00;
         // delayed release after the last rising edge in 3-wire mode
         if (rel_r != 4'h0) begin
            rel_r <= rel_r - 4'h1;
            if (rel_r == 4'h1)
               drv_r <= 1'b0; // [RQ5] [RQ6]
         end
         if (fall && state_r == ST_RD) begin
            drv_r <= 1'b1;
            dout_r <= sh_r[23];
         end
         if (swrst) begin
            ctrl_r <= `CTRL_RESET;
            state_r <= ST_CMD;
            cnt_r <= 5'h00;
            crd_r <= 1'b0;
            drv_r <= 1'b0;
            rel_r <= 4'h0;
            ones_r <= 7'h00;
            err_r <= 3'h0;
         end else if (cs_rise) begin
            // 4-wire: interface reset, output returns to data-ready
            state_r <= ST_CMD; // [RQ10]
            cnt_r <= 5'h00;
            crd_r <= 1'b0;
            drv_r <= 1'b0; // [RQ11]
            rel_r <= 4'h0;
         end else if (conv_abort_in && state_r == ST_RD && crd_r) begin
            // result dropped so data-ready goes high unless a second result is buffered
            pop_r <= head_valid; // [RQ15]
            drv_r <= 1'b0;
            crd_r <= 1'b0;
            cnt_r <= 5'h00;
            state_r <= four_wire ? ST_DONE : ST_CMD;
         end else begin
            case (state_r)
               ST_CMD: begin
                  if (cont) begin
                     if (cont_start) begin
                        sh_r <= data_word; // [RQ1] [RQ14]
                        len_r <= dlen;
                        cnt_r <= 5'h00;
                        crd_r <= 1'b1;
                        isdata_r <= 1'b1;
                        addr_r <= `ADDR_DATA;
                        state_r <= ST_RD;
                     end
                  end else if (rise) begin
                     cmd_r <= cmd_w;
                     cnt_r <= cnt_r + 5'h01;
                     if (cnt_r == 5'h07) begin
                        cnt_r <= 5'h00;
                        addr_r <= cmd_w[5:0];
                        len_r <= dec_len;
                        if (is_rd) begin
                           sh_r <= dec_val;
                           isdata_r <= (cmd_w[5:0] == `ADDR_DATA);
                           state_r <= ST_RD;
                        end else begin
                           wrok_r <= dec_wr;
                           state_r <= ST_WR;
                        end
                     end
                  end
               end
               ST_RD: begin
                  if (rise) begin
                     sh_r <= {sh_r[22:0], 1'b0};
                     cmd_r <= cmd_w;
                     cnt_r <= cnt_r + 5'h01;
                     if (crd_r && cnt_r == 5'h07 && cmd_w == `CMD_READ_DATA) begin
                        // leave continuous read, restart as a plain data read
                        ctrl_r[`CTRL_CONT_BIT] <= 1'b0; // [RQ16]
                        crd_r <= 1'b0;
                        cnt_r <= 5'h00;
                        sh_r <= data_word;
                        len_r <= dlen;
                     end else if (last) begin
                        cnt_r <= 5'h00;
                        crd_r <= 1'b0;
                        if (isdata_r && head_valid)
                           pop_r <= 1'b1; // [RQ14]
                        if (four_wire) begin
                           state_r <= ST_DONE;
                        end else begin
                           state_r <= ST_CMD; // [RQ4]
                           rel_r <= rel_cyc; // [RQ5] [RQ6] [RQ13]
                        end
                     end
                  end
               end
               ST_WR: begin
                  if (rise) begin
                     wr_r <= {wr_r[14:0], din_s};
                     cnt_r <= cnt_r + 5'h01;
                     if (last) begin
                        cnt_r <= 5'h00;
                        if (wrok_r)
                           ctrl_r <= {wr_r[14:0], din_s} & `CTRL_WMASK;
                        state_r <= four_wire ? ST_DONE : ST_CMD; // [RQ4]
                     end
                  end
               end
               default: begin
                  // clocks past the frame wait for chip select to rise
                  if (!four_wire)
                     state_r <= ST_CMD;
               end
            endcase
         end
         // pin: data while reading, else data-ready if routed there
         dout_out <= drv_r ? dout_r : ~head_valid; // [RQ5] [RQ11]
         dout_oe_n_out <= ~(~cs_n_s & (drv_r | rdy_on_dout_in)); // [RQ9]
      end
   end
endmodule // adc_serial_port

// ---- src/buf2.v ----
/*
 Two-entry buffer with valid/ready on both sides.
 Assumes both sides run on the same clock.
*/
`timescale 1ns/1ps
module buf2 #(
   parameter WIDTH = 24
) (
   // clock and control
   input wire clk_in,
   input wire rst_in,
   input wire ce_in,
   // fill side
   input wire [WIDTH-1:0] in_data_in,
   input wire in_valid_in,
   output wire in_ready_out,
   // drain side
   output wire [WIDTH-1:0] out_data_out,
   output wire out_valid_out,
   input wire out_ready_in
);
   reg [WIDTH-1:0] mem0_r;
   reg [WIDTH-1:0] mem1_r;
   reg wp_r;
   reg rp_r;
   reg [1:0] cnt_r;
   wire push;
   wire pop;

   assign in_ready_out = (cnt_r != 2'h2);
   assign out_valid_out = (cnt_r != 2'h0);
   assign out_data_out = rp_r ? mem1_r : mem0_r;
   assign push = in_valid_in & in_ready_out;
   assign pop = out_ready_in & out_valid_out;

   always @(posedge clk_in) begin
      if (rst_in) begin
         mem0_r <= {WIDTH{1'b0}};
         mem1_r <= {WIDTH{1'b0}};
         wp_r <= 1'b0;
         rp_r <= 1'b0;
         cnt_r <= 2'h0;
      end else if (ce_in) begin
         if (push) begin
            if (wp_r)
               mem1_r <= in_data_in;
            else
               mem0_r <= in_data_in;
            wp_r <= ~wp_r;
         end
         if (pop)
            rp_r <= ~rp_r;
         case ({push, pop})
            2'h2: cnt_r <= cnt_r + 2'h1;
            2'h1: cnt_r <= cnt_r - 2'h1;
            default: cnt_r <= cnt_r;
         endcase
      end
   end
endmodule // buf2

// ---- src/sync2.v ----
/*
 Two flip-flop synchroniser for a group of asynchronous inputs.
 Assumes inputs come from outside the core clock domain.
*/
`timescale 1ns/1ps
module sync2 #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
   // clock and control
   input wire clk_in,
   input wire rst_in,
   input wire ce_in,
   // data
   input wire [WIDTH-1:0] d_in,
   output reg [WIDTH-1:0] q_out
);
   reg [WIDTH-1:0] meta_r;

   always @(posedge clk_in) begin
      if (rst_in) begin
         meta_r <= RST_VAL;
         q_out <= RST_VAL;
      end else if (ce_in) begin
         meta_r <= d_in;
         q_out <= meta_r;
      end
   end
endmodule // sync2
